// file: design/mlat_core.v
// MII side sequencer of a 10/100 transceiver: carrier sense, collision,
// receive data timing and transmit latency for all three line modes.
// Assumes line-side decoder levels and the MII clock arrive asynchronously
// and that every level stays stable for at least two system clocks.
`timescale 1ns/1ps
`include "mlat_defs.vh"

module mlat_core (
    input wire mclk,
    input wire rst_n,
    input wire mii_clk,
    input wire [3:0] mac_txd,
    input wire mac_tx_en,
    input wire mac_tx_er,
    input wire line_rx_j,
    input wire line_rx_t,
    input wire line_rx_active,
    input wire [3:0] line_rx_pair,
    input wire line_rx_err,
    input wire cfg_speed_100,
    input wire cfg_fibre,
    output reg [3:0] mac_rxd,
    output reg mac_rx_dv,
    output reg mac_rx_er,
    output reg mac_crs,
    output reg mac_col,
    output reg [3:0] line_tx_pair,
    output reg line_tx_en,
    output reg line_tx_er
);
    // One-hot operating modes.
    localparam [2:0] MODE_TP100 = 3'b001;
    localparam [2:0] MODE_FX100 = 3'b010;
    localparam [2:0] MODE_TP10 = 3'b100;

    // Converts tenths of a bit time to cycles, rounding up, never below one.
    function [7:0] to_cyc;
        input [15:0] tenths, bt_ns;
        reg [31:0] prod, q;
        begin
            prod = tenths * bt_ns;
            q = (prod + (10 * `MLAT_CLK_NS) - 1) / (10 * `MLAT_CLK_NS);
            if (q == 32'h0)
                q = 32'h1;
            to_cyc = q[7:0];
        end
    endfunction

    // Picks one of three per-mode values.
    function [7:0] by_mode;
        input [2:0] m;
        input [7:0] v_tp, v_fx, v_10;
        begin
            case (m)
                MODE_TP100: by_mode = v_tp;
                MODE_FX100: by_mode = v_fx;
                MODE_TP10: by_mode = v_10;
                default: by_mode = v_tp;
            endcase
        end
    endfunction

    localparam [7:0] C_CRS_DV100 = to_cyc(`MLAT_CRS_TO_DV100_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_J_CRS = to_cyc(`MLAT_J_TO_CRS_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_T_CRS_TP = to_cyc(`MLAT_T_TO_CRS_TP_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_T_CRS_FX = to_cyc(`MLAT_T_TO_CRS_FX_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_J_COL_TP = to_cyc(`MLAT_J_TO_COL_TP_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_J_COL_FX = to_cyc(`MLAT_J_TO_COL_FX_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_T_COL_TP = to_cyc(`MLAT_T_TO_COL_TP_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_T_COL_FX = to_cyc(`MLAT_T_TO_COL_FX_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXON_TP = to_cyc(`MLAT_TXEN_CRS_ON_TP_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXON_FX = to_cyc(`MLAT_TXEN_CRS_ON_FX_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXOFF_TP = to_cyc(`MLAT_TXEN_CRS_OFF_TP_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXOFF_FX = to_cyc(`MLAT_TXEN_CRS_OFF_FX_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXLAT_TP = to_cyc(`MLAT_TX_LAT_TP_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXLAT_FX = to_cyc(`MLAT_TX_LAT_FX_MIN, `MLAT_BT100_NS);
    localparam [7:0] C_TXLAT_10 = to_cyc(`MLAT_TX_LAT_T10_TYP, `MLAT_BT10_NS);
    localparam [7:0] C_RXLAT_10 = to_cyc(`MLAT_RX_LAT_T10_MIN, `MLAT_BT10_NS);
    localparam [7:0] C_CRS_DV10 = to_cyc(`MLAT_CRS_TO_DV10_MIN, `MLAT_BT10_NS);
    localparam [7:0] C_DV_CRS10 = to_cyc(`MLAT_DV_TO_CRS10_MIN, `MLAT_BT10_NS);
    localparam [7:0] C_ACT_CRS10 = to_cyc(`MLAT_ACT_TO_CRS10_MIN, `MLAT_BT10_NS);
    localparam [7:0] C_QUIET_CRS10 = to_cyc(`MLAT_QUIET_TO_CRS10_MIN, `MLAT_BT10_NS);
    localparam [7:0] C_ACT_COL10 = to_cyc(`MLAT_ACT_TO_COL10_MIN, `MLAT_BT10_NS);
    localparam [7:0] C_QUIET_COL10 = to_cyc(`MLAT_QUIET_TO_COL10_MIN, `MLAT_BT10_NS);

    // Synchronised copies of every asynchronous input.
    wire [`MLAT_SYNC_W-1:0] sync_bus;
    wire [3:0] s_txd, s_rx_pair;
    wire s_mii_clk, s_tx_en, s_tx_er, s_rx_j, s_rx_t, s_rx_active, s_rx_err, s_speed_100, s_fibre;

    mlat_sync #(
        .W(`MLAT_SYNC_W)
    ) u_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .async_in({mii_clk, mac_txd, mac_tx_en, mac_tx_er, line_rx_j, line_rx_t,
                   line_rx_active, line_rx_pair, line_rx_err, cfg_speed_100, cfg_fibre}),
        .sync_out(sync_bus)
    );

    assign {s_mii_clk, s_txd, s_tx_en, s_tx_er, s_rx_j, s_rx_t,
            s_rx_active, s_rx_pair, s_rx_err, s_speed_100, s_fibre} = sync_bus;

    // Previous values for edge detection, all taken after the synchroniser.
    reg clk_prev, j_prev, t_prev;
    wire clk_rise, clk_fall, j_start, t_start;

    assign clk_rise = s_mii_clk & ~clk_prev;
    assign clk_fall = ~s_mii_clk & clk_prev;
    assign j_start = s_rx_j & ~j_prev;
    assign t_start = s_rx_t & ~t_prev;

    always @(posedge mclk) begin
        if (!rst_n) begin
            clk_prev <= 1'b0;
            j_prev <= 1'b0;
            t_prev <= 1'b0;
        end else begin
            clk_prev <= s_mii_clk;
            j_prev <= s_rx_j;
            t_prev <= s_rx_t;
        end
    end

    // Mode register; a change is applied only while the link is idle so that
    // a frame never mixes two latency sets.
    reg [2:0] mode, next_mode;
    wire link_idle;

    always @* begin
        if (!s_speed_100)
            next_mode = MODE_TP10;
        else if (s_fibre)
            next_mode = MODE_FX100;
        else
            next_mode = MODE_TP100;
    end

    always @(posedge mclk) begin
        if (!rst_n)
            mode <= MODE_TP10;
        else if (link_idle)
            mode <= next_mode;
    end

    // Transmit inputs latched on the MII clock rise.
    reg [3:0] txd_q;
    reg tx_en_q, tx_er_q;

    always @(posedge mclk) begin
        if (!rst_n) begin
            txd_q <= 4'h0;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end else if (clk_rise) begin
            txd_q <= s_txd;
            tx_en_q <= s_tx_en;
            tx_er_q <= s_tx_er;
        end
    end

    // Stream state at 100 Mb/s: opened by J, closed by T.
    reg stream;

    always @(posedge mclk) begin
        if (!rst_n)
            stream <= 1'b0;
        else if (j_start)
            stream <= 1'b1;
        else if (t_start)
            stream <= 1'b0;
    end

    // Idle also waits for the delayed line output, which outlives tx_en_q by the latency.
    assign link_idle = ~mac_crs & ~tx_en_q & ~stream & ~line_tx_en;

    // Receive activity as a level, per speed.
    wire rx_level, is10;

    assign is10 = (mode == MODE_TP10);
    assign rx_level = is10 ? s_rx_active : stream;

    // Receive carrier sense timing.
    wire crs_rx;
    wire [7:0] crs_rx_on, crs_rx_off;

    assign crs_rx_on = by_mode(mode, C_J_CRS, C_J_CRS, C_ACT_CRS10);
    assign crs_rx_off = by_mode(mode, C_T_CRS_TP, C_T_CRS_FX, C_QUIET_CRS10);

    mlat_delay u_crs_rx (
        .clk(mclk),
        .rst_n(rst_n),
        .level_in(rx_level),
        .rise_cyc(crs_rx_on),
        .fall_cyc(crs_rx_off),
        .level_out(crs_rx)
    );

    // Data valid follows receive carrier sense; at 10 Mb/s it is released one
    // cycle before carrier sense so that carrier always outlasts the data.
    wire dv_raw;
    wire [7:0] dv_on, dv_off;

    assign dv_on = is10 ? C_CRS_DV10 : C_CRS_DV100;
    assign dv_off = is10 ? (C_QUIET_CRS10 - C_DV_CRS10) : 8'h01;

    mlat_delay u_dv (
        .clk(mclk),
        .rst_n(rst_n),
        .level_in(crs_rx & rx_level),
        .rise_cyc(dv_on),
        .fall_cyc(dv_off),
        .level_out(dv_raw)
    );

    // Collision: receive activity while the MAC transmits.
    wire col_raw;
    wire [7:0] col_on, col_off;

    assign col_on = by_mode(mode, C_J_COL_TP, C_J_COL_FX, C_ACT_COL10);
    assign col_off = by_mode(mode, C_T_COL_TP, C_T_COL_FX, C_QUIET_COL10);

    mlat_delay u_col (
        .clk(mclk),
        .rst_n(rst_n),
        .level_in(rx_level & tx_en_q),
        .rise_cyc(col_on),
        .fall_cyc(col_off),
        .level_out(col_raw)
    );

    // Carrier sense raised by own transmission.
    wire crs_tx;
    wire [7:0] txcrs_on, txcrs_off;

    assign txcrs_on = by_mode(mode, C_TXON_TP, C_TXON_FX, C_TXON_TP);
    assign txcrs_off = by_mode(mode, C_TXOFF_TP, C_TXOFF_FX, C_TXOFF_TP);

    mlat_delay u_crs_tx (
        .clk(mclk),
        .rst_n(rst_n),
        .level_in(tx_en_q & ~is10),
        .rise_cyc(txcrs_on),
        .fall_cyc(txcrs_off),
        .level_out(crs_tx)
    );

    // Carrier sense and collision are not tied to the MII clock.
    always @(posedge mclk) begin
        if (!rst_n) begin
            mac_crs <= 1'b0;
            mac_col <= 1'b0;
        end else begin
            // at 10 Mb/s, carrier outlasts data valid, whatever the clock phase.
            mac_crs <= crs_rx | crs_tx | (is10 & tx_en_q) | (is10 & mac_rx_dv);
            mac_col <= col_raw;
        end
    end

    // Receive history, shifted every cycle, gives the 10 Mb/s data latency.
    reg [4:0] rx_hist [0:`MLAT_RXBUF_DEPTH-1];
    wire [2:0] rx_tap;
    wire [4:0] rx_word;
    genvar gi;

    assign rx_tap = is10 ? (C_RXLAT_10[2:0] - 3'h1) : 3'h0;
    assign rx_word = rx_hist[rx_tap];

    always @(posedge mclk) begin
        if (!rst_n)
            rx_hist[0] <= 5'h00;
        else
            rx_hist[0] <= {s_rx_err, s_rx_pair};
    end

    generate
        for (gi = 1; gi < `MLAT_RXBUF_DEPTH; gi = gi + 1) begin : g_rx_hist
            always @(posedge mclk) begin
                if (!rst_n)
                    rx_hist[gi] <= 5'h00;
                else
                    rx_hist[gi] <= rx_hist[gi-1];
            end
        end
    endgenerate

    // Receive outputs change only on the MII clock fall, so they stand still
    // around the rise where the MAC samples them.
    // fall update
    always @(posedge mclk) begin
        if (!rst_n) begin
            mac_rxd <= 4'h0;
            mac_rx_dv <= 1'b0;
            mac_rx_er <= 1'b0;
        end else if (clk_fall) begin
            mac_rx_dv <= dv_raw;
            mac_rxd <= dv_raw ? rx_word[3:0] : 4'h0;
            mac_rx_er <= dv_raw & rx_word[4];
        end
    end

    // Transmit history: a circular buffer written every cycle and read a
    // mode-dependent distance behind, which covers the long 10 Mb/s delay.
    reg [5:0] tx_buf [0:`MLAT_TXBUF_DEPTH-1];
    reg [`MLAT_TXBUF_AW-1:0] wr_ptr;
    wire [7:0] tx_lat;
    wire [`MLAT_TXBUF_AW-1:0] rd_ptr;
    wire [5:0] tx_word;

    assign tx_lat = by_mode(mode, C_TXLAT_TP, C_TXLAT_FX, C_TXLAT_10);
    assign rd_ptr = wr_ptr - tx_lat[`MLAT_TXBUF_AW-1:0] + 7'h01;
    // A one-cycle latency reads the live word, since its slot is rewritten at this edge.
    assign tx_word = (rd_ptr == wr_ptr) ? {tx_er_q, tx_en_q, txd_q} : tx_buf[rd_ptr];

    always @(posedge mclk) begin
        tx_buf[wr_ptr] <= {tx_er_q, tx_en_q, txd_q};
    end

    always @(posedge mclk) begin
        if (!rst_n)
            wr_ptr <= 7'h00;
        else
            wr_ptr <= wr_ptr + 7'h01;
    end

    // Holds the line idle after reset until the write pointer first reaches tx_lat, since
    // the array itself carries no reset.
    reg buf_primed;

    always @(posedge mclk) begin
        if (!rst_n)
            buf_primed <= 1'b0;
        else if (wr_ptr == 7'h7f)
            buf_primed <= 1'b1;
    end

    // Line transmit outputs.
    always @(posedge mclk) begin
        if (!rst_n || (!buf_primed && wr_ptr < tx_lat[`MLAT_TXBUF_AW-1:0])) begin
            line_tx_pair <= 4'h0;
            line_tx_en <= 1'b0;
            line_tx_er <= 1'b0;
        end else begin
            line_tx_pair <= tx_word[3:0];
            line_tx_en <= tx_word[4];
            line_tx_er <= tx_word[5];
        end
    end
endmodule // mlat_core

// file: design/mlat_defs.vh
// Constants of the MII latency sequencer: clock rate, bit periods and delays.
// Delays are held in tenths of a bit time so that fractional figures stay exact.
`ifndef MLAT_DEFS_VH
`define MLAT_DEFS_VH

// System clock period in ns (10 MHz).
`define MLAT_CLK_NS 100
// Interface bit periods in ns.
`define MLAT_BT100_NS 10
`define MLAT_BT10_NS 100

// 100 Mb/s receive: carrier sense ahead of valid data, tenths of BT.
`define MLAT_CRS_TO_DV100_MIN 30
`define MLAT_CRS_TO_DV100_MAX 50
// 100 Mb/s receive: start of J to carrier sense.
`define MLAT_J_TO_CRS_MIN 120
`define MLAT_J_TO_CRS_MAX 160
// Start of T to carrier sense dropped, twisted pair and fibre.
`define MLAT_T_TO_CRS_TP_MIN 100
`define MLAT_T_TO_CRS_TP_MAX 170
`define MLAT_T_TO_CRS_FX_MIN 160
`define MLAT_T_TO_CRS_FX_MAX 220
// Start of J to collision, twisted pair and fibre.
`define MLAT_J_TO_COL_TP_MIN 160
`define MLAT_J_TO_COL_TP_MAX 220
`define MLAT_J_TO_COL_FX_MIN 100
`define MLAT_J_TO_COL_FX_MAX 150
// Start of T to collision dropped.
`define MLAT_T_TO_COL_TP_MIN 170
`define MLAT_T_TO_COL_TP_MAX 200
`define MLAT_T_TO_COL_FX_MIN 140
`define MLAT_T_TO_COL_FX_MAX 180
// Transmit enable to carrier sense on and off at 100 Mb/s.
`define MLAT_TXEN_CRS_ON_TP_MIN 200
`define MLAT_TXEN_CRS_ON_TP_MAX 240
`define MLAT_TXEN_CRS_ON_FX_MIN 170
`define MLAT_TXEN_CRS_ON_FX_MAX 200
`define MLAT_TXEN_CRS_OFF_TP_MIN 240
`define MLAT_TXEN_CRS_OFF_TP_MAX 280
`define MLAT_TXEN_CRS_OFF_FX_MIN 220
`define MLAT_TXEN_CRS_OFF_FX_MAX 240
// Transmit latency to the line output.
`define MLAT_TX_LAT_TP_MIN 53
`define MLAT_TX_LAT_TP_MAX 57
`define MLAT_TX_LAT_FX_MIN 50
`define MLAT_TX_LAT_FX_MAX 53
`define MLAT_TX_LAT_T10_TYP 725
// 10 Mb/s receive figures.
`define MLAT_RX_LAT_T10_MIN 42
`define MLAT_RX_LAT_T10_MAX 66
`define MLAT_CRS_TO_DV10_MIN 50
`define MLAT_CRS_TO_DV10_MAX 320
`define MLAT_DV_TO_CRS10_MIN 3
`define MLAT_DV_TO_CRS10_MAX 5
`define MLAT_ACT_TO_CRS10_MIN 20
`define MLAT_ACT_TO_CRS10_MAX 280
`define MLAT_QUIET_TO_CRS10_MIN 60
`define MLAT_QUIET_TO_CRS10_MAX 100
`define MLAT_ACT_TO_COL10_MIN 10
`define MLAT_ACT_TO_COL10_MAX 310
`define MLAT_QUIET_TO_COL10_MIN 50
`define MLAT_QUIET_TO_COL10_MAX 100

// Transmit history depth and index width.
`define MLAT_TXBUF_DEPTH 128
`define MLAT_TXBUF_AW 7
// Receive history depth.
`define MLAT_RXBUF_DEPTH 8
// Width of the synchronised input bundle.
`define MLAT_SYNC_W 17

`endif

// file: design/mlat_delay.v
// Level delay with separate rise and fall delays counted in clock cycles.
// Assumes delay values of at least one cycle; a change that reverts before
// its delay runs out is swallowed, which filters glitches on the line side.
`timescale 1ns/1ps
module mlat_delay (
    input wire clk,
    input wire rst_n,
    input wire level_in,
    input wire [7:0] rise_cyc,
    input wire [7:0] fall_cyc,
    output reg level_out
);
    reg [7:0] cnt;
    wire [7:0] target;
    wire [7:0] cnt_inc;

    assign target = level_in ? rise_cyc : fall_cyc;
    assign cnt_inc = cnt + 8'h01;

    // Output follows the input once it has differed for the target count.
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            level_out <= 1'b0;
        end else if (level_in == level_out) begin
            cnt <= 8'h00;
        end else if (cnt_inc >= target) begin
            level_out <= level_in;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt_inc;
        end
    end
endmodule // mlat_delay

// file: design/mlat_sync.v
// Two-flip-flop synchroniser for a bundle of independent level inputs.
// Each bit is assumed to be a slow level; bits are not coherent as a word.
`timescale 1ns/1ps
module mlat_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta;

    // The first stage feeds only the second stage.
    always @(posedge clk) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // mlat_sync

// file: tb/mlat_core_monitor.sv
// Timing checker for the MII sequencer: carrier, collision and receive data.
// Assumes speed and media settings only change while the link is idle.
`timescale 1ns/1ps
module mlat_core_monitor (
    input logic mclk,
    input logic rst_n,
    input logic mii_clk,
    input logic mac_tx_en,
    input logic line_rx_j,
    input logic line_rx_t,
    input logic line_rx_active,
    input logic cfg_speed_100,
    input logic [3:0] mac_rxd,
    input logic mac_rx_dv,
    input logic mac_crs,
    input logic mac_col
);
    // One clock domain, so clocking and reset are given once for all checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Bounds are wider than the line figures where the synchroniser adds cycles.
    property p_crs10_on; $rose(line_rx_active) && !cfg_speed_100 |-> ##[2:28] mac_crs; endproperty
    a_crs10_on: assert property (p_crs10_on) else $error("carrier late after activity");
    property p_crs10_off; $fell(line_rx_active) && !cfg_speed_100 && !mac_tx_en |-> mac_crs[*6] ##[1:5] !mac_crs;
    endproperty
    a_crs10_off: assert property (p_crs10_off) else $error("carrier drop off after quiet");
    property p_dv_late; $rose(mac_rx_dv) && !cfg_speed_100 |-> $past(mac_crs, 5); endproperty
    a_dv_late: assert property (p_dv_late) else $error("data valid too soon after carrier");
    // Receive outputs may only move while the interface clock is low.
    property p_rx_stable; !$stable(mac_rxd) || !$stable(mac_rx_dv) |-> !mii_clk; endproperty
    a_rx_stable: assert property (p_rx_stable) else $error("receive data moved near clock rise");
    property p_crs_j; $rose(line_rx_j) && cfg_speed_100 |-> ##[2:8] mac_crs; endproperty
    a_crs_j: assert property (p_crs_j) else $error("carrier late after start code");
    property p_crs_t; $rose(line_rx_t) && cfg_speed_100 && !mac_tx_en |-> ##[1:8] !mac_crs; endproperty
    a_crs_t: assert property (p_crs_t) else $error("carrier stays after end code");
    property p_col_j; $rose(line_rx_j) && cfg_speed_100 && mac_tx_en |-> ##[1:8] mac_col; endproperty
    a_col_j: assert property (p_col_j) else $error("collision late after start code");
    property p_col_t; $rose(line_rx_t) && cfg_speed_100 |-> ##[1:8] !mac_col; endproperty
    a_col_t: assert property (p_col_t) else $error("collision stays after end code");
    property p_tx_crs; $rose(mac_tx_en) && cfg_speed_100 |-> ##[2:16] mac_crs; endproperty
    a_tx_crs: assert property (p_tx_crs) else $error("carrier late after transmit enable");
endmodule // mlat_core_monitor

// file: tb/mlat_mac_model.sv
// MAC model for the MII side: sends a frame of nibbles and samples received ones.
// Assumes a free-running interface clock that is unrelated to the system clock.
`timescale 1ns/1ps
module mlat_mac_model (
    input wire mclk,
    input wire rst_n,
    input wire mii_clk,
    input wire tx_go,
    input wire [7:0] tx_len,
    input wire [3:0] mac_rxd,
    input wire mac_rx_dv,
    output reg [3:0] mac_txd,
    output reg mac_tx_en,
    output reg mac_tx_er,
    output reg [3:0] rx_last
);
    reg ck_q;
    reg [7:0] left;

    // change just after fall
    // Lines move just after the clock falls, so they stay settled through the rise
    // even after the block's two-stage synchroniser; an idle nibble is inverted junk.
    always @(posedge mclk) begin
        ck_q <= mii_clk;
        if (!rst_n) begin
            left <= 8'h00;
            mac_tx_en <= 1'b0;
            mac_tx_er <= 1'b0;
            mac_txd <= 4'h0;
        end else if (ck_q && !mii_clk) begin
            mac_tx_en <= (left != 8'h00);
            mac_tx_er <= (left == 8'h02);
            mac_txd <= (left != 8'h00) ? left[3:0] : ~mac_txd;
            left <= (left != 8'h00) ? left - 8'h01 : 8'h00;
        end else if (tx_go && left == 8'h00 && !mac_tx_en) begin
            left <= tx_len;
        end
    end

    always @(posedge mclk) begin
        if (!ck_q && mii_clk && mac_rx_dv) begin
            rx_last <= mac_rxd;
        end
    end
endmodule // mlat_mac_model

// file: tb/tb_phy_mii_latency_sequencing.sv
// Testbench for the MII sequencer: 10 Mb/s, then 100 Mb/s copper and fibre.
// Assumes the sequencer, its checker and the MAC model are compiled first.
`timescale 1ns/1ps
module tb_phy_mii_latency_sequencing;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic mii_clk = 1'b0;
    logic line_rx_j = 1'b0;
    logic line_rx_t = 1'b0;
    logic line_rx_active = 1'b0;
    logic [3:0] line_rx_pair = 4'h0;
    logic line_rx_err = 1'b0;
    logic cfg_speed_100 = 1'b0;
    logic cfg_fibre = 1'b0;
    logic tx_go = 1'b0;
    logic [7:0] tx_len = 8'h00;
    wire [3:0] mac_txd, mac_rxd, line_tx_pair, rx_last;
    wire mac_tx_en, mac_tx_er, mac_rx_dv, mac_rx_er, mac_crs, mac_col, line_tx_en, line_tx_er;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n, m;
    int toff[2];
    int jcol[2];

    mlat_core uut (.mclk, .rst_n, .mii_clk, .mac_txd, .mac_tx_en, .mac_tx_er, .line_rx_j, .line_rx_t,
        .line_rx_active, .line_rx_pair, .line_rx_err, .cfg_speed_100, .cfg_fibre, .mac_rxd, .mac_rx_dv,
        .mac_rx_er, .mac_crs, .mac_col, .line_tx_pair, .line_tx_en, .line_tx_er);
    mlat_mac_model mac (.mclk, .rst_n, .mii_clk, .tx_go, .tx_len, .mac_rxd, .mac_rx_dv, .mac_txd,
        .mac_tx_en, .mac_tx_er, .rx_last);

    // The interface clock is offset so its edges never meet the system clock's.
    initial forever #50 mclk = ~mclk;
    initial begin
        #37;
        forever #400 mii_clk = ~mii_clk;
    end

    // Range compare for cycle counts, and exact compare for design values.
    task automatic chk(input string what, input int lo, input int hi, input int seen);
        comparisons++;
        if (seen < lo || seen > hi) begin
            bad_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, seen);
        end
    endtask
    task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] seen);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Counts edges until the chosen output reaches a level, giving up after 300.
    task automatic wait_sig(input int sel, input logic val, output int k);
        logic s;
        k = 0;
        do begin
            @(posedge mclk);
            #1;
            k++;
            s = (sel == 0) ? mac_crs : (sel == 1) ? mac_col : (sel == 2) ? mac_rx_dv :
                (sel == 3) ? line_tx_en : (sel == 4) ? mac_tx_en : line_tx_er;
        end while (s !== val && k < 300);
    endtask

    // One received frame at 10 Mb/s with no transmit in progress.
    task automatic rx10();
        @(posedge mclk);
        line_rx_pair <= 4'h5;
        line_rx_err <= 1'b1;
        line_rx_active <= 1'b1;
        wait_sig(0, 1'b1, n);
        chk("crs after activity", 2, 28, n); // carrier rise
        wait_sig(2, 1'b1, m);
        chk("crs ahead of dv", 5, 32, m); // carrier lead
        chk4("rx nibble", 4'h5, mac_rxd); // receive data
        chk4("rx error", 4'h1, {3'h0, mac_rx_er}); // receive error
        repeat (40) @(posedge mclk);
        chk4("nibble at mac", 4'h5, rx_last); // stable sample
        line_rx_active <= 1'b0;
        line_rx_err <= 1'b0;
        wait_sig(0, 1'b0, n);
        chk("crs after quiet", 6, 10, n); // carrier drop
        chk4("dv at crs drop", 4'h0, {3'h0, mac_rx_dv}); // data first
    endtask

    // A 10 Mb/s frame that meets line activity part way through.
    task automatic col10();
        @(posedge mclk);
        tx_len <= 8'd20;
        tx_go <= 1'b1;
        @(posedge mclk);
        tx_go <= 1'b0;
        wait_sig(4, 1'b1, n);
        wait_sig(3, 1'b1, n);
        chk("10M tx latency", 73, 88, n); // long latency
        @(posedge mclk);
        line_rx_active <= 1'b1;
        wait_sig(1, 1'b1, n);
        chk("col after activity", 1, 31, n); // collision rise
        repeat (20) @(posedge mclk);
        line_rx_active <= 1'b0;
        wait_sig(1, 1'b0, n);
        chk("col after quiet", 5, 10, n); // collision drop
        wait_sig(4, 1'b0, n);
        repeat (100) @(posedge mclk);
    endtask

    // A clean receive frame, then a transmit frame hit by a receive, at 100 Mb/s.
    task automatic run100(input int fib);
        @(posedge mclk);
        cfg_speed_100 <= 1'b1;
        cfg_fibre <= fib[0];
        repeat (10) @(posedge mclk);
        line_rx_j <= 1'b1;
        wait_sig(0, 1'b1, n);
        chk("crs after J", 2, 8, n); // carrier rise
        @(posedge mclk);
        line_rx_j <= 1'b0;
        repeat (20) @(posedge mclk);
        line_rx_t <= 1'b1;
        wait_sig(0, 1'b0, n);
        chk("crs after T", 1, 8, n); // carrier drop
        toff[fib] = n;
        @(posedge mclk);
        line_rx_t <= 1'b0;
        tx_len <= 8'd6;
        tx_go <= 1'b1;
        @(posedge mclk);
        tx_go <= 1'b0;
        wait_sig(4, 1'b1, n);
        wait_sig(3, 1'b1, n);
        chk("100M tx latency", 1, 12, n); // line output
        chk4("first line nibble", 4'h6, line_tx_pair); // line data
        wait_sig(0, 1'b1, m);
        chk("crs after tx enable", 2, 16, n + m); // carrier rise
        @(posedge mclk);
        line_rx_j <= 1'b1;
        wait_sig(1, 1'b1, n);
        chk("col after J", 1, 8, n); // collision rise
        jcol[fib] = n;
        @(posedge mclk);
        line_rx_j <= 1'b0;
        repeat (3) @(posedge mclk);
        line_rx_t <= 1'b1;
        wait_sig(1, 1'b0, n);
        chk("col after T", 1, 8, n); // collision drop
        @(posedge mclk);
        line_rx_t <= 1'b0;
        wait_sig(5, 1'b1, n);
        chk4("errored line nibble", 4'h2, line_tx_pair); // line error
        wait_sig(4, 1'b0, n);
        wait_sig(0, 1'b0, n);
        chk("crs after tx end", 2, 16, n); // carrier drop
        repeat (20) @(posedge mclk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole run needs about 650 cycles, so a hang is cut off at 5000.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end

    // Reset, then 10 Mb/s work, then both 100 Mb/s media.
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        chk4("outputs in reset", 4'h0, {mac_crs, mac_col, mac_rx_dv, line_tx_en});
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        rx10();
        col10();
        run100(0);
        run100(1);
        chk("fibre drop offset", 1, 1, toff[1] - toff[0]); // media set
        chk("fibre col offset", 1, 1, jcol[0] - jcol[1]); // media set
        give_verdict();
    end
endmodule // tb_phy_mii_latency_sequencing

bind mlat_core mlat_core_monitor mon (.mclk, .rst_n, .mii_clk, .mac_tx_en, .line_rx_j, .line_rx_t,
    .line_rx_active, .cfg_speed_100, .mac_rxd, .mac_rx_dv, .mac_crs, .mac_col);
